// ### core/dcrc_pkg.sv
/*
  package for the dsp core run-control register group: offsets, field layout,
  reset values and core state codes.
  assumes a 16-bit register port with word addresses as printed.
*/
package dcrc_pkg;
  // =====================================================
  // register offsets (word addresses)
  localparam logic [15:0] ADDR_HIBERNATE = 16'hF400;
  localparam logic [15:0] ADDR_RUN_TRIGGER = 16'hF402;
  localparam logic [15:0] ADDR_ABORT_TRIGGER = 16'hF403;
  localparam logic [15:0] ADDR_ENTRY_POINT = 16'hF404;
  localparam logic [15:0] ADDR_CORE_STATE = 16'hF405;
  // =====================================================
  // field layout and reset values
  localparam int TRIGGER_BIT = 0;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  // =====================================================
  // core state codes
  localparam logic [2:0] CODE_NOT_RUNNING = 3'h0;
  localparam logic [2:0] CODE_RUNNING = 3'h1;
  localparam logic [2:0] CODE_PAUSED = 3'h2;
  localparam logic [2:0] CODE_SLEEPING = 3'h3;
  localparam logic [2:0] CODE_STALLED = 3'h4;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_PAUSE,
    ST_SLEEP,
    ST_STALL
  } dcrc_state_t;
endpackage

// ### core/dcrc_run_control.sv
/*
  run-control register group of the audio dsp core: run and abort triggers,
  program entry point, controlled sleep, and a read-only core state field.
  assumes the core reports pause and sleep events and the selected frame start
  pulse as single-cycle inputs and holds the conflict input high for the length of a stall, all synchronous to clk.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
// Functional notes
// RULE_01: rising run-trigger enables core and launches program counter.
// RULE_02: falling run-trigger has no effect on the core.
// RULE_03: rising abort-trigger halts core at once, in any state.
// RULE_04: falling abort-trigger has no effect on the core.
// RULE_05: after abort, state field reads not-running code.
// RULE_06: program counter loads from the 16-bit entry-point register on start.
// RULE_07: state field reads not-running after boot.
// RULE_08: state field reads running while the core executes normally.
// RULE_09: pause instruction gates core clock, state field shows paused.
// RULE_10: sleep instruction idles core until next sample, shows sleep code.
// RULE_11: multiple requests stall core a few cycles, shows stalled code.
// RULE_12: state register is read-only; writes to it are ignored.
// RULE_13: software uses abort only for debug, controlled sleep for stopping.
// RULE_14: controlled sleep masks interrupts and sleeps after current sample.
// RULE_15: frame start pulse marks each frame; sleeping core waits for it.
// RULE_16: trigger edges found by comparing new write with stored bit.
module dcrc_run_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  input wire logic pauseReq,
  input wire logic resumeReq,
  input wire logic sleepReq,
  input wire logic requestConflict,
  input wire logic frameStart,
  input wire logic blockDone,
  output logic coreEnable,
  output logic coreClockEnable,
  output logic pcLoad,
  output logic [15:0] pcLoadValue,
  output logic coreHalt,
  output logic irqMask
);
  // =====================================================
  // register state
  logic runTrig_reg, runTrig_next;
  logic abortTrig_reg, abortTrig_next;
  logic hibernate_reg, hibernate_next;
  logic [15:0] entry_reg, entry_next;
  logic [15:0] rdData_reg, rdData_next;
  logic runPulse, abortPulse;
  logic wrRun, wrAbort;

  // write decode and trigger edge detection against the stored bit
  always_comb
  begin
    wrRun = regWrEn && (regAddr == dcrc_pkg::ADDR_RUN_TRIGGER);
    wrAbort = regWrEn && (regAddr == dcrc_pkg::ADDR_ABORT_TRIGGER);
    runPulse = wrRun && regWrData[dcrc_pkg::TRIGGER_BIT] && !runTrig_reg; // see RULE_16
    abortPulse = wrAbort && regWrData[dcrc_pkg::TRIGGER_BIT] && !abortTrig_reg; // see RULE_16
    runTrig_next = wrRun ? regWrData[dcrc_pkg::TRIGGER_BIT] : runTrig_reg; // see RULE_02
    abortTrig_next = wrAbort ? regWrData[dcrc_pkg::TRIGGER_BIT] : abortTrig_reg; // see RULE_04
    hibernate_next = hibernate_reg;
    if (regWrEn && regAddr == dcrc_pkg::ADDR_HIBERNATE)
    begin
      hibernate_next = regWrData[0];
    end
    entry_next = entry_reg;
    if (regWrEn && regAddr == dcrc_pkg::ADDR_ENTRY_POINT)
    begin
      entry_next = regWrData;
    end
  end

  // =====================================================
  // core state machine
  dcrc_pkg::dcrc_state_t state_reg, state_next;
  logic sleepPending_reg, sleepPending_next;

  // next state; abort wins over every other event
  always_comb
  begin
    state_next = state_reg;
    sleepPending_next = sleepPending_reg;
    if (!hibernate_reg)
    begin
      sleepPending_next = 1'b0;
    end
    if (abortPulse)
    begin
      state_next = dcrc_pkg::ST_IDLE; // see RULE_03
      sleepPending_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        dcrc_pkg::ST_IDLE:
        begin
          if (runPulse)
          begin
            state_next = dcrc_pkg::ST_RUN; // see RULE_01
          end
        end
        dcrc_pkg::ST_RUN:
        begin
          if (hibernate_reg && blockDone)
          begin
            state_next = dcrc_pkg::ST_SLEEP; // see RULE_14
            sleepPending_next = 1'b1;
          end
          else if (requestConflict)
          begin
            state_next = dcrc_pkg::ST_STALL; // see RULE_11
          end
          else if (pauseReq)
          begin
            state_next = dcrc_pkg::ST_PAUSE; // see RULE_09
          end
          else if (sleepReq)
          begin
            state_next = dcrc_pkg::ST_SLEEP; // see RULE_10
          end
        end
        dcrc_pkg::ST_PAUSE:
        begin
          if (resumeReq)
          begin
            state_next = dcrc_pkg::ST_RUN;
          end
        end
        dcrc_pkg::ST_SLEEP:
        begin
          // controlled sleep holds here until hibernate is cleared and a frame start arrives
          if (frameStart && !(hibernate_reg && sleepPending_reg))
          begin
            state_next = dcrc_pkg::ST_RUN; // see RULE_15
          end
        end
        dcrc_pkg::ST_STALL:
        begin
          if (!requestConflict)
          begin
            state_next = dcrc_pkg::ST_RUN; // see RULE_11
          end
        end
        default:
        begin
          state_next = dcrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // outputs and read mux
  logic coreEnable_next, clkEn_next, pcLoad_next, halt_next, irqMask_next;
  logic [15:0] pcVal_next;
  logic [2:0] stateCode;

  always_comb
  begin
    unique case (state_reg)
      dcrc_pkg::ST_RUN: stateCode = dcrc_pkg::CODE_RUNNING; // see RULE_08
      dcrc_pkg::ST_PAUSE: stateCode = dcrc_pkg::CODE_PAUSED; // see RULE_09
      dcrc_pkg::ST_SLEEP: stateCode = dcrc_pkg::CODE_SLEEPING; // see RULE_10
      dcrc_pkg::ST_STALL: stateCode = dcrc_pkg::CODE_STALLED; // see RULE_11
      default: stateCode = dcrc_pkg::CODE_NOT_RUNNING; // see RULE_05, RULE_07
    endcase
    coreEnable_next = (state_next != dcrc_pkg::ST_IDLE);
    clkEn_next = (state_next == dcrc_pkg::ST_RUN) || (state_next == dcrc_pkg::ST_SLEEP);
    pcLoad_next = runPulse && !abortPulse && (state_reg == dcrc_pkg::ST_IDLE); // see RULE_06
    pcVal_next = pcLoad_next ? entry_reg : pcLoadValue;
    halt_next = abortPulse; // see RULE_03
    irqMask_next = hibernate_next; // see RULE_14
    rdData_next = dcrc_pkg::UNMAPPED_READ;
    if (regRdEn)
    begin
      unique case (regAddr)
        dcrc_pkg::ADDR_HIBERNATE: rdData_next = {15'h0000, hibernate_reg};
        dcrc_pkg::ADDR_RUN_TRIGGER: rdData_next = {15'h0000, runTrig_reg};
        dcrc_pkg::ADDR_ABORT_TRIGGER: rdData_next = {15'h0000, abortTrig_reg};
        dcrc_pkg::ADDR_ENTRY_POINT: rdData_next = entry_reg;
        dcrc_pkg::ADDR_CORE_STATE: rdData_next = {13'h0000, stateCode}; // see RULE_12
        default: rdData_next = dcrc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // register bank: trigger bits, controlled sleep and entry point
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      runTrig_reg <= 1'b0;
      abortTrig_reg <= 1'b0;
      hibernate_reg <= 1'b0;
      entry_reg <= dcrc_pkg::RESET_WORD;
    end
    else
    begin
      runTrig_reg <= runTrig_next;
      abortTrig_reg <= abortTrig_next;
      hibernate_reg <= hibernate_next;
      entry_reg <= entry_next;
    end
  end

  // core state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= dcrc_pkg::ST_IDLE; // see RULE_07
      sleepPending_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sleepPending_reg <= sleepPending_next;
    end
  end

  // registered outputs and read data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_reg <= dcrc_pkg::RESET_WORD;
      coreEnable <= 1'b0;
      coreClockEnable <= 1'b0;
      pcLoad <= 1'b0;
      pcLoadValue <= dcrc_pkg::RESET_WORD;
      coreHalt <= 1'b0;
      irqMask <= 1'b0;
    end
    else
    begin
      rdData_reg <= rdData_next;
      coreEnable <= coreEnable_next;
      coreClockEnable <= clkEn_next;
      pcLoad <= pcLoad_next;
      pcLoadValue <= pcVal_next;
      coreHalt <= halt_next;
      irqMask <= irqMask_next; // see RULE_14
    end
  end

  assign regRdData = rdData_reg;

  // =====================================================
  // checks
  a_run_starts: assert property (@(posedge clk) disable iff (rst) // see RULE_01
    (state_reg == dcrc_pkg::ST_IDLE && runPulse && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_RUN && coreEnable && pcLoad))
    else $error("run trigger did not start core");
  a_run_fall_ignored: assert property (@(posedge clk) disable iff (rst) // see RULE_02
    (wrRun && !regWrData[dcrc_pkg::TRIGGER_BIT] && !abortPulse)
    |=> ((state_reg == dcrc_pkg::ST_IDLE) == ($past(state_reg) == dcrc_pkg::ST_IDLE)))
    else $error("run trigger fall changed core state");
  a_abort_halts: assert property (@(posedge clk) disable iff (rst) // see RULE_03
    abortPulse |=> (state_reg == dcrc_pkg::ST_IDLE && coreHalt && !coreEnable))
    else $error("abort did not halt core");
  a_abort_fall_ignored: assert property (@(posedge clk) disable iff (rst) // see RULE_04
    (wrAbort && !regWrData[0] && !runPulse) |=> !coreHalt)
    else $error("abort fall had effect");
  a_abort_status: assert property (@(posedge clk) disable iff (rst) // see RULE_05
    (abortPulse ##1 (regRdEn && regAddr == dcrc_pkg::ADDR_CORE_STATE))
    |=> regRdData == 16'h0000)
    else $error("status not idle after abort");
  a_entry_loaded: assert property (@(posedge clk) disable iff (rst) // see RULE_06
    pcLoad |-> pcLoadValue == $past(entry_reg))
    else $error("pc not loaded from entry point");
  a_status_read: assert property (@(posedge clk) disable iff (rst) // see RULE_08
    (regRdEn && regAddr == dcrc_pkg::ADDR_CORE_STATE && state_reg == dcrc_pkg::ST_RUN)
    |=> regRdData == 16'h0001)
    else $error("running code not reported");
  a_pause_gates: assert property (@(posedge clk) disable iff (rst) // see RULE_09
    (state_reg == dcrc_pkg::ST_PAUSE) |-> !coreClockEnable)
    else $error("paused core clock not gated");
  a_stall_resume: assert property (@(posedge clk) disable iff (rst) // see RULE_11
    (state_reg == dcrc_pkg::ST_STALL && !requestConflict && !abortPulse)
    |=> state_reg == dcrc_pkg::ST_RUN)
    else $error("stall did not resume");
  a_irq_mask: assert property (@(posedge clk) disable iff (rst) // see RULE_14
    irqMask == hibernate_reg)
    else $error("interrupt mask differs from hibernate");
  a_boot_idle: assert property (@(posedge clk) disable iff (rst) // see RULE_07
    $fell(rst) |-> (state_reg == dcrc_pkg::ST_IDLE && !coreEnable && !coreClockEnable))
    else $error("core not idle after reset");
  a_run_clocked: assert property (@(posedge clk) disable iff (rst) // see RULE_08
    (state_reg == dcrc_pkg::ST_RUN) |-> (coreEnable && coreClockEnable))
    else $error("running core not enabled and clocked");
  a_pause_holds: assert property (@(posedge clk) disable iff (rst) // see RULE_09
    (state_reg == dcrc_pkg::ST_PAUSE && !resumeReq && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_PAUSE))
    else $error("paused core left pause without resume");
  a_sleep_enters: assert property (@(posedge clk) disable iff (rst) // see RULE_10
    (state_reg == dcrc_pkg::ST_RUN && sleepReq && !pauseReq && !requestConflict
      && !hibernate_reg && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_SLEEP && coreClockEnable))
    else $error("sleep instruction did not enter sleep");
  a_stall_enters: assert property (@(posedge clk) disable iff (rst) // see RULE_11
    (state_reg == dcrc_pkg::ST_RUN && requestConflict && !(hibernate_reg && blockDone)
      && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_STALL && !coreClockEnable))
    else $error("request conflict did not stall core");
  a_state_readonly: assert property (@(posedge clk) disable iff (rst) // see RULE_12
    (regWrEn && regAddr == dcrc_pkg::ADDR_CORE_STATE && state_reg == dcrc_pkg::ST_IDLE)
    |=> (state_reg == dcrc_pkg::ST_IDLE))
    else $error("write to core state changed it");
  a_hib_enters: assert property (@(posedge clk) disable iff (rst) // see RULE_14
    (state_reg == dcrc_pkg::ST_RUN && hibernate_reg && blockDone && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_SLEEP && sleepPending_reg))
    else $error("controlled sleep not entered after block");
  a_hib_holds: assert property (@(posedge clk) disable iff (rst) // see RULE_14
    (state_reg == dcrc_pkg::ST_SLEEP && sleepPending_reg && hibernate_reg && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_SLEEP))
    else $error("controlled sleep woke while still set");
  a_sleep_waits: assert property (@(posedge clk) disable iff (rst) // see RULE_15
    (state_reg == dcrc_pkg::ST_SLEEP && !frameStart && !abortPulse)
    |=> (state_reg == dcrc_pkg::ST_SLEEP))
    else $error("sleeping core woke without frame start");
  a_pc_single: assert property (@(posedge clk) disable iff (rst) // see RULE_16
    pcLoad |=> !pcLoad)
    else $error("program counter load longer than one cycle");
endmodule

// ### verification/dsp_core_run_control_bench.sv
/*
  self-checking bench for the dsp core run-control register group.
  assumes the design answers reads one cycle after the strobe and that its
  registered outputs follow a write in the cycle after the write strobe.
*/
`timescale 1ns/10ps
module dsp_core_run_control_bench;
  logic clk, rst, regWrEn, regRdEn, pauseReq, resumeReq, sleepReq;
  logic requestConflict, frameStart, blockDone;
  logic coreEnable, coreClockEnable, pcLoad, coreHalt, irqMask;
  logic [15:0] regAddr, regWrData, regRdData, pcLoadValue;
  int mismatches = 0;
  int checks = 0;
  // =====================================================
  // design under test
  dcrc_run_control u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .pauseReq(pauseReq),
    .resumeReq(resumeReq), .sleepReq(sleepReq), .requestConflict(requestConflict),
    .frameStart(frameStart), .blockDone(blockDone), .coreEnable(coreEnable),
    .coreClockEnable(coreClockEnable), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .coreHalt(coreHalt), .irqMask(irqMask));
  // =====================================================
  // shared tasks
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write, returns just after the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask
  // one-cycle read, data taken in the cycle after the strobe
  task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  task automatic state(input logic [2:0] code);
    rdChk(dcrc_pkg::ADDR_CORE_STATE, {13'h0000, code});
  endtask
  // verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // =====================================================
  // scenarios
  task automatic resetValues();
    state(dcrc_pkg::CODE_NOT_RUNNING);
    rdChk(dcrc_pkg::ADDR_ENTRY_POINT, dcrc_pkg::RESET_WORD);
    rdChk(dcrc_pkg::ADDR_RUN_TRIGGER, dcrc_pkg::RESET_WORD);
    chk({15'h0000, coreEnable}, 16'h0000);
  endtask
  task automatic startCore();
    wr(dcrc_pkg::ADDR_ENTRY_POINT, 16'hA5C3);
    wr(dcrc_pkg::ADDR_RUN_TRIGGER, 16'h0001);
    chk({14'h0000, pcLoad, coreEnable}, 16'h0003);
    chk(pcLoadValue, 16'hA5C3);
    @(posedge clk);
    #1;
    chk({15'h0000, pcLoad}, 16'h0000);
    state(dcrc_pkg::CODE_RUNNING);
    wr(dcrc_pkg::ADDR_RUN_TRIGGER, 16'h0000);
    chk({14'h0000, pcLoad, coreEnable}, 16'h0001);
  endtask
  task automatic pauseStallSleep();
    @(posedge clk) pauseReq <= 1'b1;
    @(posedge clk) pauseReq <= 1'b0;
    state(dcrc_pkg::CODE_PAUSED);
    chk({15'h0000, coreClockEnable}, 16'h0000);
    @(posedge clk) resumeReq <= 1'b1;
    @(posedge clk) resumeReq <= 1'b0;
    state(dcrc_pkg::CODE_RUNNING);
    @(posedge clk) requestConflict <= 1'b1;
    state(dcrc_pkg::CODE_STALLED);
    @(posedge clk) requestConflict <= 1'b0;
    state(dcrc_pkg::CODE_RUNNING);
    @(posedge clk) sleepReq <= 1'b1;
    @(posedge clk) sleepReq <= 1'b0;
    state(dcrc_pkg::CODE_SLEEPING);
    @(posedge clk) frameStart <= 1'b1;
    @(posedge clk) frameStart <= 1'b0;
    state(dcrc_pkg::CODE_RUNNING);
  endtask
  task automatic abortCore();
    // abort write followed with no gap by a status read
    @(posedge clk);
    regAddr <= dcrc_pkg::ADDR_ABORT_TRIGGER;
    regWrData <= 16'h0001;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regAddr <= dcrc_pkg::ADDR_CORE_STATE;
    regRdEn <= 1'b1;
    #1;
    chk({14'h0000, coreHalt, coreEnable}, 16'h0002);
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, {13'h0000, dcrc_pkg::CODE_NOT_RUNNING});
    wr(dcrc_pkg::ADDR_ABORT_TRIGGER, 16'h0000);
    chk({15'h0000, coreHalt}, 16'h0000);
    wr(dcrc_pkg::ADDR_CORE_STATE, 16'h0001);
    state(dcrc_pkg::CODE_NOT_RUNNING);
    rdChk(16'hF406, dcrc_pkg::UNMAPPED_READ);
  endtask
  task automatic controlledSleep();
    wr(dcrc_pkg::ADDR_HIBERNATE, 16'h0001);
    wr(dcrc_pkg::ADDR_RUN_TRIGGER, 16'h0001);
    chk({15'h0000, irqMask}, 16'h0001);
    @(posedge clk) blockDone <= 1'b1;
    @(posedge clk) blockDone <= 1'b0;
    state(dcrc_pkg::CODE_SLEEPING);
    wr(dcrc_pkg::ADDR_HIBERNATE, 16'h0000);
    @(posedge clk) frameStart <= 1'b1;
    @(posedge clk) frameStart <= 1'b0;
    state(dcrc_pkg::CODE_RUNNING);
  endtask
  // =====================================================
  // clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cut a hang short
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  // reset, then scenarios in order
  initial
  begin
    {rst, regWrEn, regRdEn, pauseReq, resumeReq, sleepReq} = 6'h3F & 6'h20;
    {requestConflict, frameStart, blockDone} = 3'h0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    resetValues();
    startCore();
    pauseStallSleep();
    abortCore();
    controlledSleep();
    end_sim();
  end
endmodule
